/* hdl/rtd_station.sv */
// rtd_station: topology discovery and topology frame sender of one station.
// assumes the far end on the same clock; signal fail pins are asynchronous.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
// Notes on behaviour
// - known changed source on second direction: update
// - unknown source: insert entry with hop count
// - fast expiry sends; eighth switches to slow
// - slow expiry sends and restarts slow timer
// - signal fail: zero-neighbour send, change state
// - invalid message raises misconfiguration, changes state
// - topology frame uses control kind one
// - broadcast, max hop limit, own source, strip
// - entries accepted in any order
// - type word: mandatory, reserved, ten-bit code
// - non-mandatory may be skipped, mandatory processed; only the weight code is decoded, other mandatory codes are not
// - length word: reserved, ten-bit byte count
// - value never longer than 1024 bytes
// - value is exactly length bytes long
// - weight entry mandatory, code one, length two
module rtd_station
#(
  parameter int unsigned DB_DEPTH = 8,
  parameter int unsigned SLOW_CYC = rtd_pkg::SLOW_CYC
)
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  rtd_link_if.station      link,
  input  wire logic [1:0]  signal_fail_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o
);
  localparam int unsigned IW = $clog2(DB_DEPTH);
  typedef enum logic [1:0] {
    both_neighbours_heard_state, east_heard_state, west_heard_state
  } rtd_state_t;
  typedef struct packed {
    logic        vld;
    logic [47:0] mac;
    logic [15:0] caps;
    logic [7:0]  hop0;
    logic [7:0]  hop1;
  } rtd_entry_t;
  typedef struct packed {
    rtd_state_t                 st;
    rtd_entry_t [DB_DEPTH-1:0] db;
    logic [1:0]  sf_s1;
    logic [1:0]  sf_s2;
    logic [1:0]  sf_d;
    logic [31:0] tmr;
    logic        fast;
    logic [3:0]  nexp;
    logic [1:0]  disc_tx;
    logic        nbr_zero;
    logic        busy;
    logic [3:0]  idx;
    logic        tv;
    logic [7:0]  td;
    logic        tsof;
    logic        teof;
    logic [47:0] mac;
    logic [15:0] weight;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [7:0]  strips;
    logic        ack;
    logic [31:0] rdata;
  } rtd_sta_t;
  rtd_sta_t r, n;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic           hit;
    logic           has_free;
    logic           send;
    logic           fast_go;
    logic [IW-1:0]  hidx;
    logic [IW-1:0]  fidx;
    logic [7:0]     hop;
    logic [7:0]     cnt;
    logic [3:0]     ev;
    logic [3:0]     clr;
    logic [1:0]     sf_new;
    logic           wr;
    logic [15:0]    tword;
    hit = 1'b0;
    has_free = 1'b0;
    send = 1'b0;
    fast_go = 1'b0;
    hidx = '0;
    fidx = '0;
    cnt = 8'h00;
    ev = 4'h0;
    clr = 4'h0;
    n = r;
    n.disc_tx = 2'b00;
    n.tv = 1'b0;
    n.tsof = 1'b0;
    n.teof = 1'b0;
    hop = rtd_pkg::MAX_STATION_COUNT - link.disc_rx_ttl;
    tword = {1'b1, rtd_pkg::TYPE_RSVD, rtd_pkg::WEIGHT_CODE};
    wr = r.ack && avs_write_i;
    n.sf_s1 = signal_fail_i;
    n.sf_s2 = r.sf_s1;
    n.sf_d = r.sf_s2;
    sf_new = r.sf_s2 & ~r.sf_d;
    for (int i = 0; i < DB_DEPTH; i++)
    begin
      if (r.db[i].vld) cnt = cnt + 8'h01;
      if (r.db[i].vld && r.db[i].mac == link.disc_rx_src && !hit)
      begin
        hit = 1'b1;
        hidx = IW'(i);
      end
      if (!r.db[i].vld && !has_free)
      begin
        has_free = 1'b1;
        fidx = IW'(i);
      end
    end
    // topology timers
    if (r.tmr == 32'h0000_0001)
    begin
      send = 1'b1;
      if (r.fast && r.nexp + 4'h1 == rtd_pkg::FAST_EXPIRIES)
      begin
        n.fast = 1'b0;
        n.tmr = 32'(SLOW_CYC);
      end
      else if (r.fast)
      begin
        n.nexp = r.nexp + 4'h1;
        n.tmr = 32'(rtd_pkg::FAST_CYC);
      end
      else n.tmr = 32'(SLOW_CYC);
    end
    else if (r.tmr != 32'h0000_0000) n.tmr = r.tmr - 32'h0000_0001;
    n.nbr_zero = 1'b0;
    // local failures, then bad messages, then good messages
    if (sf_new != 2'b00)
    begin
      send = 1'b1;
      fast_go = 1'b1;
      n.nbr_zero = 1'b1;
      ev[rtd_pkg::IRQ_SIGFAIL] = 1'b1;
      n.st = sf_new[1] ? west_heard_state : east_heard_state;
    end
    else if (link.disc_rx_valid && link.disc_rx_bad)
    begin
      ev[rtd_pkg::IRQ_MISCONF] = 1'b1;
      n.st = link.disc_rx_dir ? west_heard_state : east_heard_state;
    end
    else if (link.disc_rx_valid && r.st == both_neighbours_heard_state &&
             link.disc_rx_ttl < rtd_pkg::MAX_STATION_COUNT)
    begin
      if (hit && r.db[hidx].caps != link.disc_rx_caps)
      begin
        n.db[hidx].caps = link.disc_rx_caps;
        if (link.disc_rx_dir) n.db[hidx].hop0 = hop;
        else n.db[hidx].hop1 = hop;
        send = 1'b1;
        fast_go = 1'b1;
        ev[rtd_pkg::IRQ_DBCHG] = 1'b1;
      end
      else if (!hit)
      begin
        if (has_free)
        begin
          n.db[fidx].vld = 1'b1;
          n.db[fidx].mac = link.disc_rx_src;
          n.db[fidx].caps = link.disc_rx_caps;
          n.db[fidx].hop0 = link.disc_rx_dir ? hop : 8'h00;
          n.db[fidx].hop1 = link.disc_rx_dir ? 8'h00 : hop;
        end
        send = 1'b1;
        fast_go = 1'b1;
        ev[rtd_pkg::IRQ_DBCHG] = 1'b1;
      end
    end
    if (send) n.disc_tx = 2'b11;
    if (fast_go)
    begin
      n.fast = 1'b1;
      n.nexp = 4'h0;
      n.tmr = 32'(rtd_pkg::FAST_CYC);
    end
    // topology frame serialiser
    if (r.busy)
    begin
      n.tv = 1'b1;
      n.tsof = r.idx == 4'h0;
      n.teof = r.idx == rtd_pkg::FRAME_LAST_IDX;
      unique case (r.idx)
        4'h0: n.td = rtd_pkg::CONTROL_VERSION;
        4'h1: n.td = rtd_pkg::CONTROL_KIND_TOPO;
        4'h2: n.td = tword[15:8];
        4'h3: n.td = tword[7:0];
        4'h4: n.td = {rtd_pkg::LEN_RSVD, rtd_pkg::WEIGHT_LEN[9:8]};
        4'h5: n.td = rtd_pkg::WEIGHT_LEN[7:0];
        4'h6: n.td = r.weight[7:0];
        4'h7: n.td = r.weight[15:8];
        default: n.td = 8'h00;
      endcase
      n.idx = r.idx + 4'h1;
      if (r.idx == rtd_pkg::FRAME_LAST_IDX) n.busy = 1'b0;
    end
    // own frame back round the ring is removed
    if (link.ret_valid && link.ret_src == r.mac)
    begin
      n.strips = r.strips + 8'h01;
      ev[rtd_pkg::IRQ_STRIP] = 1'b1;
    end
    // register writes
    if (wr)
    begin
      unique case (avs_address_i)
        rtd_pkg::REG_CTRL:
        begin
          if (avs_writedata_i[rtd_pkg::CTRL_SEND] && !r.busy)
          begin
            n.busy = 1'b1;
            n.idx = 4'h0;
          end
          if (avs_writedata_i[rtd_pkg::CTRL_RESYNC]) n.st = both_neighbours_heard_state;
          if (avs_writedata_i[rtd_pkg::CTRL_CLR_DB])
            for (int i = 0; i < DB_DEPTH; i++) n.db[i].vld = 1'b0;
        end
        rtd_pkg::REG_MAC_LO:   n.mac[31:0] = avs_writedata_i;
        rtd_pkg::REG_MAC_HI:   n.mac[47:32] = avs_writedata_i[15:0];
        rtd_pkg::REG_WEIGHT:   n.weight = avs_writedata_i[15:0];
        rtd_pkg::REG_IRQ_STAT: clr = avs_writedata_i[3:0];
        rtd_pkg::REG_IRQ_MASK: n.irq_mask = avs_writedata_i[3:0];
        default: n.irq_mask = r.irq_mask;
      endcase
    end
    n.irq_stat = (r.irq_stat & ~clr) | ev;
    // register reads
    n.ack = (avs_read_i || avs_write_i) && !r.ack;
    unique case (avs_address_i)
      rtd_pkg::REG_STATUS:
        n.rdata = {r.strips, cnt, r.nexp, 3'h0, r.fast, 6'h00, r.st};
      rtd_pkg::REG_MAC_LO:   n.rdata = r.mac[31:0];
      rtd_pkg::REG_MAC_HI:   n.rdata = {16'h0000, r.mac[47:32]};
      rtd_pkg::REG_WEIGHT:   n.rdata = {16'h0000, r.weight};
      rtd_pkg::REG_IRQ_STAT: n.rdata = {28'h000_0000, r.irq_stat};
      rtd_pkg::REG_IRQ_MASK: n.rdata = {28'h000_0000, r.irq_mask};
      default:               n.rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.st <= both_neighbours_heard_state;
      r.fast <= 1'b1;
      r.mac <= rtd_pkg::MAC_RST;
      r.weight <= rtd_pkg::WEIGHT_RST;
      r.irq_mask <= rtd_pkg::MASK_RST;
    end
    else r <= n;
  end

  assign link.disc_tx       = r.disc_tx;
  assign link.disc_nbr_zero = r.nbr_zero;
  assign link.topo_valid    = r.tv;
  assign link.topo_data     = r.td;
  assign link.topo_sof      = r.tsof;
  assign link.topo_eof      = r.teof;
  assign link.topo_ttl      = rtd_pkg::MAX_STATION_COUNT;
  assign link.topo_src      = r.mac;
  assign avs_readdata_o     = r.rdata;
  assign avs_waitrequest_o  = (avs_read_i || avs_write_i) && !r.ack;
  assign irq_o              = |(r.irq_stat & r.irq_mask);
endmodule // rtd_station

/* hdl/rtd_pkg.sv */
// rtd_pkg: constants shared by both ring-station ends and the entry parser.
// assumes a single 50 MHz station clock.
package rtd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned FAST_PERIOD_US = 10;
  localparam int unsigned SLOW_PERIOD_MS = 1;
  localparam int unsigned FAST_CYC       = FAST_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLOW_CYC       = SLOW_PERIOD_MS * (CLK_HZ / 1_000);
  localparam logic [3:0]  FAST_EXPIRIES  = 4'h8;
  // ----------------------------------------------------------------
  // frame and entry layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  MAX_STATION_COUNT = 8'hff;
  localparam logic [7:0]  CONTROL_KIND_TOPO = 8'h01;
  localparam logic [7:0]  CONTROL_VERSION   = 8'h00;
  localparam int unsigned MAND_BIT          = 15;
  localparam int unsigned CODE_W            = 10;
  localparam logic [9:0]  WEIGHT_CODE       = 10'h001;
  localparam logic [9:0]  WEIGHT_LEN        = 10'h002;
  localparam logic [4:0]  TYPE_RSVD         = 5'h00;
  localparam logic [5:0]  LEN_RSVD          = 6'h00;
  localparam logic [3:0]  FRAME_LAST_IDX    = 4'h7;
  // ----------------------------------------------------------------
  // registers (word index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h1;
  localparam logic [3:0]  REG_MAC_LO   = 4'h2;
  localparam logic [3:0]  REG_MAC_HI   = 4'h3;
  localparam logic [3:0]  REG_WEIGHT   = 4'h4;
  localparam logic [3:0]  REG_IRQ_STAT = 4'h5;
  localparam logic [3:0]  REG_IRQ_MASK = 4'h6;
  localparam int unsigned CTRL_SEND    = 0;
  localparam int unsigned CTRL_RESYNC  = 1;
  localparam int unsigned CTRL_CLR_DB  = 2;
  localparam int unsigned IRQ_MISCONF  = 0;
  localparam int unsigned IRQ_SIGFAIL  = 1;
  localparam int unsigned IRQ_DBCHG    = 2;
  localparam int unsigned IRQ_STRIP    = 3;
  localparam logic [15:0] WEIGHT_RST   = 16'h0101;
  localparam logic [47:0] MAC_RST      = 48'h0000_0000_0000;
  localparam logic [3:0]  MASK_RST     = 4'h0;
endpackage

/* hdl/rtd_link_if.sv */
// rtd_link_if: link between a ring station and the far stations.
// assumes both ends share clock_i; all signals are same-domain.
`timescale 1ns/1ns
interface rtd_link_if;
  logic [1:0]  disc_tx;
  logic        disc_nbr_zero;
  logic        topo_valid;
  logic [7:0]  topo_data;
  logic        topo_sof;
  logic        topo_eof;
  logic [7:0]  topo_ttl;
  logic [47:0] topo_src;
  logic        disc_rx_valid;
  logic        disc_rx_dir;
  logic [7:0]  disc_rx_ttl;
  logic [47:0] disc_rx_src;
  logic [15:0] disc_rx_caps;
  logic        disc_rx_bad;
  logic        ret_valid;
  logic [47:0] ret_src;
  modport station (output disc_tx, disc_nbr_zero, topo_valid, topo_data, topo_sof,
                   topo_eof, topo_ttl, topo_src,
                   input  disc_rx_valid, disc_rx_dir, disc_rx_ttl, disc_rx_src,
                   disc_rx_caps, disc_rx_bad, ret_valid, ret_src);
  modport far (input  disc_tx, disc_nbr_zero, topo_valid, topo_data, topo_sof,
               topo_eof, topo_ttl, topo_src,
               output disc_rx_valid, disc_rx_dir, disc_rx_ttl, disc_rx_src,
               disc_rx_caps, disc_rx_bad, ret_valid, ret_src);
endinterface

/* hdl/rtd_tlv_parse.sv */
// rtd_tlv_parse: walks the entries of a topology frame byte stream.
// assumes bytes from the same clock domain, sof on control version byte.
`timescale 1ns/1ns
module rtd_tlv_parse
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        valid_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        sof_i,
  input  wire logic        eof_i,
  output logic             entry_valid_o,
  output logic             entry_mand_o,
  output logic [9:0]       entry_code_o,
  output logic [9:0]       entry_len_o,
  output logic             skip_o,
  output logic             malformed_o,
  output logic             weight_valid_o,
  output logic [15:0]      weight_o
);
  typedef enum logic [2:0] {P_IDLE, P_KIND, P_T0, P_T1, P_L0, P_L1, P_VAL} rtd_pst_t;
  typedef struct packed {
    rtd_pst_t    st;
    logic        mand;
    logic [9:0]  code;
    logic [9:0]  len;
    logic [9:0]  cnt;
    logic [15:0] val;
    logic        ev;
    logic        skip;
    logic        bad;
    logic        wv;
  } rtd_pstate_t;
  rtd_pstate_t r, n;

  // ----------------------------------------------------------------
  // entry walker
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [9:0] len;
    len = 10'h000;
    n = r;
    n.ev = 1'b0;
    n.skip = 1'b0;
    n.bad = 1'b0;
    n.wv = 1'b0;
    if (valid_i)
    begin
      if (sof_i) n.st = P_KIND;
      else
      begin
        unique case (r.st)
          P_IDLE: n.st = P_IDLE;
          P_KIND: n.st = (data_i == rtd_pkg::CONTROL_KIND_TOPO) ? P_T0 : P_IDLE;
          P_T0:
          begin
            n.mand = data_i[rtd_pkg::MAND_BIT - 8];
            n.code[9:8] = data_i[1:0];
            n.st = P_T1;
          end
          P_T1:
          begin
            n.code[7:0] = data_i;
            n.st = P_L0;
          end
          P_L0:
          begin
            n.len[9:8] = data_i[1:0];
            n.st = P_L1;
          end
          P_L1:
          begin
            // ten-bit count can never pass the 1024 byte ceiling
            len = {r.len[9:8], data_i};
            n.len = len;
            n.cnt = len;
            n.val = 16'h0000;
            if (len == 10'h000)
            begin
              n.ev = 1'b1;
              n.st = P_T0;
            end
            else n.st = P_VAL;
          end
          P_VAL:
          begin
            if (r.cnt > r.len - 10'h002) n.val = {r.val[7:0], data_i};
            n.cnt = r.cnt - 10'h001;
            if (r.cnt == 10'h001)
            begin
              n.ev = 1'b1;
              n.st = P_T0;
            end
          end
          default: n.st = P_IDLE;
        endcase
        if (n.ev)
        begin
          n.wv = r.mand && r.code == rtd_pkg::WEIGHT_CODE;
          n.skip = !r.mand && r.code != rtd_pkg::WEIGHT_CODE;
        end
        if (eof_i)
        begin
          n.bad = r.st != P_IDLE && !(n.st == P_T0 && r.st != P_KIND);
          n.st = P_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      r <= '0;
      r.st <= P_IDLE;
    end
    else r <= n;
  end

  assign entry_valid_o  = r.ev;
  assign entry_mand_o   = r.mand;
  assign entry_code_o   = r.code;
  assign entry_len_o    = r.len;
  assign skip_o         = r.skip;
  assign malformed_o    = r.bad;
  assign weight_valid_o = r.wv;
  assign weight_o       = r.val;
endmodule // rtd_tlv_parse

/* hdl/rtd_far_station.sv */
// rtd_far_station: the other ring stations as seen by one station.
// assumes the bench drives the inject ports on clock_i.
`timescale 1ns/1ns
module rtd_far_station
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  rtd_link_if.far          link,
  input  wire logic        inj_valid_i,
  input  wire logic        inj_dir_i,
  input  wire logic [7:0]  inj_ttl_i,
  input  wire logic [47:0] inj_src_i,
  input  wire logic [15:0] inj_caps_i,
  input  wire logic        inj_bad_i,
  output logic [1:0]       disc_seen_o,
  output logic             nbr_zero_o,
  output logic             entry_valid_o,
  output logic             entry_mand_o,
  output logic [9:0]       entry_code_o,
  output logic [9:0]       entry_len_o,
  output logic             skip_o,
  output logic             malformed_o,
  output logic             weight_valid_o,
  output logic [15:0]      weight_o
);
  typedef struct packed {
    logic        dv;
    logic        dir;
    logic [7:0]  ttl;
    logic [47:0] src;
    logic [15:0] caps;
    logic        bad;
    logic [1:0]  seen;
    logic        nz;
    logic [47:0] fsrc;
    logic        rv;
  } rtd_far_t;
  rtd_far_t r, n;

  // ----------------------------------------------------------------
  // discovery injection and frame return
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.dv = inj_valid_i;
    n.dir = inj_dir_i;
    n.ttl = inj_ttl_i;
    n.src = inj_src_i;
    n.caps = inj_caps_i;
    n.bad = inj_bad_i;
    n.seen = link.disc_tx;
    n.nz = link.disc_nbr_zero;
    n.rv = 1'b0;
    if (link.topo_valid && link.topo_sof) n.fsrc = link.topo_src;
    // broadcast comes back round to its source
    if (link.topo_valid && link.topo_eof) n.rv = 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i) r <= '0;
    else r <= n;
  end

  rtd_tlv_parse u_parse
  (
    .clock_i        (clock_i),
    .reset_n_i      (reset_n_i),
    .valid_i        (link.topo_valid),
    .data_i         (link.topo_data),
    .sof_i          (link.topo_sof),
    .eof_i          (link.topo_eof),
    .entry_valid_o  (entry_valid_o),
    .entry_mand_o   (entry_mand_o),
    .entry_code_o   (entry_code_o),
    .entry_len_o    (entry_len_o),
    .skip_o         (skip_o),
    .malformed_o    (malformed_o),
    .weight_valid_o (weight_valid_o),
    .weight_o       (weight_o)
  );

  assign link.disc_rx_valid = r.dv;
  assign link.disc_rx_dir   = r.dir;
  assign link.disc_rx_ttl   = r.ttl;
  assign link.disc_rx_src   = r.src;
  assign link.disc_rx_caps  = r.caps;
  assign link.disc_rx_bad   = r.bad;
  assign link.ret_valid     = r.rv;
  assign link.ret_src       = r.fsrc;
  assign disc_seen_o        = r.seen;
  assign nbr_zero_o         = r.nz;
endmodule // rtd_far_station

/* bench/rtd_link_assertions.sv */
// rtd_link_assertions: wire checks on the station-to-far link.
// assumes plain copies of the link signals and the station clock and reset.
`timescale 1ns/1ns
module rtd_link_assertions
(
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic [1:0] disc_tx,
  input wire logic       disc_nbr_zero,
  input wire logic       topo_valid,
  input wire logic [7:0] topo_data,
  input wire logic       topo_sof,
  input wire logic       topo_eof,
  input wire logic [7:0] topo_ttl,
  input wire logic       disc_rx_valid,
  input wire logic [7:0] disc_rx_ttl,
  input wire logic       ret_valid
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------------------------------
  // frame sequences
  // ----------------------------------------------------------------
  sequence kind_s;
    topo_data == 8'h00 ##1 topo_data == 8'h01;
  endsequence
  sequence weight_hdr_s;
    topo_data == 8'h80 ##1 topo_data == 8'h01 ##1 topo_data == 8'h00 ##1 topo_data == 8'h02;
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_kind_one: assert property (topo_sof |-> kind_s)
    else $error("control kind wrong");
  chk_weight_hdr: assert property (topo_sof |-> ##2 weight_hdr_s)
    else $error("weight entry header wrong");
  chk_frame_bytes: assert property (topo_sof |-> topo_valid [*8])
    else $error("frame bytes not contiguous");
  chk_frame_end: assert property (topo_sof |-> ##7 topo_eof)
    else $error("frame end misplaced");
  chk_ttl_max: assert property (topo_valid |-> topo_ttl == 8'hff)
    else $error("hop limit not maximum");
  chk_strip_ret: assert property (ret_valid |-> $past(topo_eof))
    else $error("return without frame end");
  chk_disc_both: assert property (disc_tx != 2'b00 |-> disc_tx == 2'b11)
    else $error("discovery not on both directions");
  chk_zero_with: assert property (disc_nbr_zero |-> disc_tx == 2'b11)
    else $error("zero neighbour without send");
  chk_max_quiet: assert property (disc_rx_valid && disc_rx_ttl == 8'hff |=> disc_tx == 2'b00)
    else $error("send on maximum hop limit");
endmodule // rtd_link_assertions

/* bench/tb_top.sv */
// tb_top: station and far stations joined by the link, driven over Avalon.
// assumes the design files under hdl and a small slow timer count.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic clock_i = 0, reset_n_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, irq_o;
  logic inj_valid_i = 0, inj_dir_i = 0, inj_bad_i = 0, nbr_zero_o, entry_valid_o, entry_mand_o;
  logic skip_o, malformed_o, weight_valid_o;
  logic [1:0] signal_fail_i = 0, disc_seen_o;
  logic [3:0] avs_address_i = 0;
  logic [7:0] inj_ttl_i = 0;
  logic [9:0] entry_code_o, entry_len_o;
  logic [15:0] inj_caps_i = 0, weight_o;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, rd;
  logic [47:0] inj_src_i = 0;
  int err_count = 0, total_checks = 0, cyc = 0, hits, zero, gap;
  always #10 clock_i = ~clock_i;
  rtd_link_if rtd_link_if_i ();
  rtd_station #(.SLOW_CYC(40)) rtd_station_i (.link(rtd_link_if_i), .*);
  rtd_far_station rtd_far_station_i (.link(rtd_link_if_i), .*);
  rtd_link_assertions rtd_link_assertions_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .disc_tx(rtd_link_if_i.disc_tx), .disc_nbr_zero(rtd_link_if_i.disc_nbr_zero),
    .topo_valid(rtd_link_if_i.topo_valid), .topo_data(rtd_link_if_i.topo_data),
    .topo_sof(rtd_link_if_i.topo_sof), .topo_eof(rtd_link_if_i.topo_eof),
    .topo_ttl(rtd_link_if_i.topo_ttl), .disc_rx_valid(rtd_link_if_i.disc_rx_valid),
    .disc_rx_ttl(rtd_link_if_i.disc_rx_ttl), .ret_valid(rtd_link_if_i.ret_valid));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test;
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clock_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic inject(input logic d, input logic [7:0] t, s, input logic [15:0] c, input logic b);
    @(posedge clock_i);
    inj_valid_i <= 1'b1;
    inj_dir_i   <= d;
    inj_ttl_i   <= t;
    inj_src_i   <= {40'h0, s};
    inj_caps_i  <= c;
    inj_bad_i   <= b;
    @(posedge clock_i);
    inj_valid_i <= 1'b0;
  endtask
  task automatic look(input int n);
    hits = 0;
    zero = 0;
    repeat (n)
    begin
      @(posedge clock_i);
      hits += int'(disc_seen_o === 2'b11);
      zero += int'(nbr_zero_o === 1'b1);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    bus(0, rtd_pkg::REG_WEIGHT, 0);
    `CHK(rd[15:0], rtd_pkg::WEIGHT_RST)
    bus(0, 4'h7, 0);
    `CHK(rd, 32'h0000_0000)
    bus(1, rtd_pkg::REG_WEIGHT, 32'h0000_1234);
    bus(1, rtd_pkg::REG_MAC_LO, 32'h0000_abcd);
    bus(0, rtd_pkg::REG_WEIGHT, 0);
    `CHK(rd[15:0], 16'h1234)
    $display("test regs done");
  endtask
  task automatic t_disc;
    inject(1, 8'hff, 8'h21, 16'h0001, 0);
    look(6);
    `CHK(hits, 0)
    inject(1, 8'hfd, 8'h21, 16'h0001, 0);
    look(6);
    `CHK(hits, 1)
    inject(1, 8'hfd, 8'h21, 16'h0001, 0);
    look(6);
    `CHK(hits, 0)
    inject(1, 8'hfd, 8'h21, 16'h0002, 0);
    look(6);
    `CHK(hits, 1)
    inject(0, 8'hf0, 8'h22, 16'h0001, 0);
    look(6);
    `CHK(hits, 1)
    bus(0, rtd_pkg::REG_STATUS, 0);
    `CHK(rd[23:16], 8'h02)
    $display("test discovery done");
  endtask
  task automatic t_timer;
    for (int i = 0; i < 10; i++)
    begin
      gap = 0;
      do
      begin
        @(posedge clock_i);
        gap++;
      end
      while (disc_seen_o !== 2'b11);
      if (i > 0)
        `CHK(gap > 450 && gap < 550, i < 8)
      `CHK(gap < 60, i >= 8)
    end
    bus(0, rtd_pkg::REG_STATUS, 0);
    `CHK(rd[8], 1'b0)
    $display("test timer done");
  endtask
  task automatic t_frame;
    bus(1, rtd_pkg::REG_CTRL, 32'h0000_0001);
    while (weight_valid_o !== 1'b1)
      @(posedge clock_i);
    `CHK({entry_mand_o, entry_code_o, entry_len_o}, {1'b1, 10'h001, 10'h002})
    `CHK(weight_o, 16'h3412)
    `CHK({entry_valid_o, skip_o, malformed_o}, 3'b100)
    repeat (4) @(posedge clock_i);
    bus(0, rtd_pkg::REG_STATUS, 0);
    `CHK(rd[31:24], 8'h01)
    $display("test frame done");
  endtask
  task automatic t_fail;
    `CHK(irq_o, 1'b0)
    bus(1, rtd_pkg::REG_IRQ_MASK, 32'h0000_0002);
    for (int k = 0; k < 4; k++)
    begin
      if (k < 2)
      begin
        signal_fail_i <= {k[0], !k[0]};
        look(10);
        `CHK(zero, 1)
        `CHK(irq_o, 1'b1)
        bus(1, rtd_pkg::REG_IRQ_STAT, 32'h0000_0002);
        @(negedge clock_i);
        `CHK(irq_o, 1'b0)
      end
      else
      begin
        inject(k[0], 8'hfd, 8'h30, 16'h0001, 1);
        look(4);
        bus(0, rtd_pkg::REG_IRQ_STAT, 0);
        `CHK(rd[0], 1'b1)
        bus(1, rtd_pkg::REG_IRQ_STAT, 32'h0000_0001);
      end
      bus(0, rtd_pkg::REG_STATUS, 0);
      `CHK(rd[1:0], {k[0], !k[0]})
      signal_fail_i <= 2'b00;
      bus(1, rtd_pkg::REG_CTRL, 32'h0000_0002);
    end
    $display("test fail done");
  endtask
  initial
  begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs;
    t_disc;
    t_timer;
    t_frame;
    t_fail;
    finish_test;
  end
endmodule // tb_top
